// file: rtl/tef_capture_detect.sv
// Edge detector for the capture input pin.
// Assumes the pin level is already synchronous to clk.
`timescale 1ns/1ps
module tef_capture_detect
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Capture side
  tef_capture_if.det cap
);

  logic pinPrev_reg;
  logic evt_reg;
  logic riseSeen;
  logic fallSeen;

  ////////////////////////////////////////////////////////////////////////////
  // Previous pin level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinPrev_reg <= 1'b0;
    end else begin
      pinPrev_reg <= cap.pinLevel;
    end
  end

  // Edge decode
  assign riseSeen = cap.pinLevel & ~pinPrev_reg;
  assign fallSeen = ~cap.pinLevel & pinPrev_reg;

  // Qualified event, only while the pin is connected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= 1'b0;
    end else begin
      evt_reg <= cap.enable & (cap.edgeRise ? riseSeen : fallSeen);
    end
  end

  assign cap.captureEvt = evt_reg;

endmodule // tef_capture_detect

// file: rtl/tef_capture_if.sv
// Interface between the flag block and its capture edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tef_capture_if;
  logic pinLevel;    // Capture pin as sampled
  logic edgeRise;    // 1: rising edge triggers, 0: falling
  logic enable;      // Capture pin connected
  logic captureEvt;  // One-cycle qualified capture event

  modport det (input pinLevel, input edgeRise, input enable, output captureEvt);
  modport ctl (output pinLevel, output edgeRise, output enable, input captureEvt);
endinterface

// file: rtl/tef_pkg.sv
// Constants, register map and mode encodings of the timer event flag block.
// Assumes a 16-bit timer counter and an APB register bus with 32-bit data.
package tef_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CNT_W  = 16;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;  // timer1_event_flags
  localparam logic [7:0] OFS_MASK  = 8'h04;  // event_mask_reg
  localparam logic [7:0] OFS_CTRL  = 8'h08;  // Mode, edge select, force strobes
  localparam logic [7:0] OFS_CMPA  = 8'h0c;  // compare_a_value
  localparam logic [7:0] OFS_CMPB  = 8'h10;  // compare_b_value
  localparam logic [7:0] OFS_CAPT  = 8'h14;  // capture_value_reg

  ////////////////////////////////////////////////////////////////////////////
  // Flag and mask bit positions (same layout in both registers)
  localparam int BIT_WRAP    = 0;
  localparam int BIT_MATCH_A = 1;
  localparam int BIT_MATCH_B = 2;
  localparam int BIT_CAPTURE = 5;
  localparam logic [REG_W-1:0] FLAG_VALID = 8'h27;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W   = 4;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_FORCE_B  = 6;
  localparam int CTRL_FORCE_A  = 7;
  localparam logic [REG_W-1:0] CTRL_STORE = 8'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [REG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [REG_W-1:0] MASK_RST  = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [CNT_W-1:0] VAL_RST   = 16'h0000;

  // Fixed counter limits
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hffff;
  localparam logic [CNT_W-1:0] TOP_8BIT   = 16'h00ff;
  localparam logic [CNT_W-1:0] TOP_9BIT   = 16'h01ff;
  localparam logic [CNT_W-1:0] TOP_10BIT  = 16'h03ff;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform mode selection encodings
  typedef enum logic [3:0] {
    MODE_NORMAL     = 4'h0, MODE_PC8       = 4'h1, MODE_PC9      = 4'h2,
    MODE_PC10       = 4'h3, MODE_CTC_CMPA  = 4'h4, MODE_FAST8    = 4'h5,
    MODE_FAST9      = 4'h6, MODE_FAST10    = 4'h7, MODE_PFC_CAPT = 4'h8,
    MODE_PFC_CMPA   = 4'h9, MODE_PC_CAPT   = 4'ha, MODE_PC_CMPA  = 4'hb,
    MODE_CTC_CAPT   = 4'hc, MODE_RESERVED  = 4'hd, MODE_FAST_CAPT = 4'he,
    MODE_FAST_CMPA  = 4'hf
  } tef_mode_t;

  // Point of the count at which the wrap flag is raised
  typedef enum logic [1:0] {
    WRAP_AT_MAX, WRAP_AT_TOP, WRAP_AT_BOTTOM, WRAP_NEVER
  } tef_wrap_t;

endpackage

// file: rtl/tef_timer_flags.sv
// Event flag logic of a 16-bit timer: flags, mask, compare and capture
// registers behind an APB slave, with per-vector interrupt requests.
// Assumes the counter itself lives outside and reports its value and a
// one-clk timer tick; the core acknowledges vectors with one-cycle pulses.
//
// Notes on behaviour
// - Flag bits 7, 6, 4, 3 read zero
// - Qualified capture pin event sets capture flag
// - Capture-top modes: flag set reaching top
// - Match B flag set tick after match
// - Force strobe B never sets match B flag
// - Match A flag set tick after match
// - Force strobe A never sets match A flag
// - Normal and clear-on-match modes: wrap on overflow
// - Other modes: wrap point follows mode
// - Vector execution clears its own flag
// - Writing one clears that flag only
// - Request needs flag, mask and global enable
// - Count write blocks compares next tick
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tef_timer_flags
  import tef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer counter status
  input  wire logic              timerTick,
  input  wire logic [CNT_W-1:0]  countValue,
  input  wire logic              countDown,
  input  wire logic              countWrite,
  // Capture pin
  input  wire logic              captureInputPin,
  // Core interrupt logic
  input  wire logic              globalIntEn,
  input  wire logic [3:0]        vectorAck,
  output logic      [3:0]        irqReq,
  output logic                   irq,
  // Waveform unit
  output logic                   compareEvtA,
  output logic                   compareEvtB,
  output logic      [CNT_W-1:0]  topValue
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [REG_W-1:0] flags_reg;
  logic [REG_W-1:0] flags_next;
  logic [REG_W-1:0] mask_reg;
  logic [REG_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] cmpA_reg;
  logic [CNT_W-1:0] cmpB_reg;
  logic [CNT_W-1:0] capt_reg;
  logic [CNT_W-1:0] top_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic             pendA_reg;
  logic             pendB_reg;
  logic             block_reg;
  logic             cmpEvtA_reg;
  logic             cmpEvtB_reg;
  logic             setup;
  logic             wrAccess;
  logic             addrHit;
  logic [REG_W-1:0] clrMask;
  logic [REG_W-1:0] setMask;
  logic             matchNowA;
  logic             matchNowB;
  logic             wrapNow;
  logic             topNow;
  logic             forceA;
  logic             forceB;
  logic [CNT_W-1:0] topSel;
  tef_mode_t        mode;
  tef_wrap_t        wrapKind;
  logic [3:0]       vecFlag;

  tef_capture_if capIf ();

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Top of the count for a mode
  function automatic logic [CNT_W-1:0] mode_top(input tef_mode_t m,
                                                input logic [CNT_W-1:0] a,
                                                input logic [CNT_W-1:0] c);
    case (m)
      MODE_PC8, MODE_FAST8:                          mode_top = TOP_8BIT;
      MODE_PC9, MODE_FAST9:                          mode_top = TOP_9BIT;
      MODE_PC10, MODE_FAST10:                        mode_top = TOP_10BIT;
      MODE_CTC_CMPA, MODE_PFC_CMPA, MODE_PC_CMPA,
      MODE_FAST_CMPA:                                mode_top = a;
      MODE_PFC_CAPT, MODE_PC_CAPT, MODE_CTC_CAPT,
      MODE_FAST_CAPT:                                mode_top = c;
      default:                                       mode_top = CNT_MAX;
    endcase
  endfunction

  // Capture value register serves as top in these modes
  function automatic logic capt_is_top(input tef_mode_t m);
    case (m)
      MODE_PFC_CAPT, MODE_PC_CAPT, MODE_CTC_CAPT, MODE_FAST_CAPT:
        capt_is_top = 1'b1;
      default:
        capt_is_top = 1'b0;
    endcase
  endfunction

  // Where the wrap flag is raised in each mode
  function automatic tef_wrap_t wrap_kind(input tef_mode_t m);
    case (m)
      MODE_NORMAL, MODE_CTC_CMPA, MODE_CTC_CAPT:     wrap_kind = WRAP_AT_MAX;
      MODE_FAST8, MODE_FAST9, MODE_FAST10,
      MODE_FAST_CAPT, MODE_FAST_CMPA:                wrap_kind = WRAP_AT_TOP;
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CAPT,
      MODE_PFC_CMPA, MODE_PC_CAPT, MODE_PC_CMPA:     wrap_kind = WRAP_AT_BOTTOM;
      default:                                       wrap_kind = WRAP_NEVER;
    endcase
  endfunction

  // Force strobes act only outside the PWM modes
  function automatic logic non_pwm(input tef_mode_t m);
    case (m)
      MODE_NORMAL, MODE_CTC_CMPA, MODE_CTC_CAPT: non_pwm = 1'b1;
      default:                                   non_pwm = 1'b0;
    endcase
  endfunction

  // Read value of a register byte offset
  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                 input logic [REG_W-1:0] f,
                                                 input logic [REG_W-1:0] k,
                                                 input logic [REG_W-1:0] t,
                                                 input logic [CNT_W-1:0] x,
                                                 input logic [CNT_W-1:0] y,
                                                 input logic [CNT_W-1:0] z);
    read_mux = '0;
    case (a)
      ADDR_W'(OFS_FLAGS): read_mux[REG_W-1:0] = f & FLAG_VALID;
      ADDR_W'(OFS_MASK):  read_mux[REG_W-1:0] = k & FLAG_VALID;
      ADDR_W'(OFS_CTRL):  read_mux[REG_W-1:0] = t & CTRL_STORE;
      ADDR_W'(OFS_CMPA):  read_mux[CNT_W-1:0] = x;
      ADDR_W'(OFS_CMPB):  read_mux[CNT_W-1:0] = y;
      ADDR_W'(OFS_CAPT):  read_mux[CNT_W-1:0] = z;
      default:            read_mux = '0;
    endcase
  endfunction

  // Address decode
  function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W'(OFS_FLAGS), ADDR_W'(OFS_MASK), ADDR_W'(OFS_CTRL),
      ADDR_W'(OFS_CMPA), ADDR_W'(OFS_CMPB), ADDR_W'(OFS_CAPT):
        addr_valid = 1'b1;
      default:
        addr_valid = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: zero wait states
  assign setup    = psel & ~penable;
  assign wrAccess = psel & penable & pwrite;
  assign addrHit  = addr_valid(paddr);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;
  assign prdata   = rdata_reg;

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (setup && !pwrite) begin
      rdata_reg <= read_mux(paddr, flags_reg, mask_reg, ctrl_reg,
                            cmpA_reg, cmpB_reg, capt_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= MASK_RST;
    end else if (wrAccess && paddr == ADDR_W'(OFS_MASK)) begin
      mask_reg <= pwdata[REG_W-1:0] & FLAG_VALID;
    end
  end

  // Control register; force bits are strobes and never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else if (wrAccess && paddr == ADDR_W'(OFS_CTRL)) begin
      ctrl_reg <= pwdata[REG_W-1:0] & CTRL_STORE;
    end
  end

  assign mode = tef_mode_t'(ctrl_reg[CTRL_MODE_LSB +: CTRL_MODE_W]);

  // Compare value registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpA_reg <= VAL_RST;
      cmpB_reg <= VAL_RST;
    end else if (wrAccess) begin
      if (paddr == ADDR_W'(OFS_CMPA)) begin
        cmpA_reg <= pwdata[CNT_W-1:0];
      end
      if (paddr == ADDR_W'(OFS_CMPB)) begin
        cmpB_reg <= pwdata[CNT_W-1:0];
      end
    end
  end

  // Capture register: loaded by capture, written only as a top value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capt_reg <= VAL_RST;
    end else if (capIf.captureEvt) begin
      capt_reg <= countValue;
    end else if (wrAccess && paddr == ADDR_W'(OFS_CAPT) && capt_is_top(mode)) begin
      capt_reg <= pwdata[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture edge detector; pin disconnected while capture holds top
  assign capIf.pinLevel = captureInputPin;
  assign capIf.edgeRise = ctrl_reg[CTRL_EDGE_BIT];
  assign capIf.enable   = ~capt_is_top(mode);

  tef_capture_detect u_capture (
    .clk   (clk),
    .rst_n (rst_n),
    .cap   (capIf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Top value held for the waveform unit
  assign topSel = mode_top(mode, cmpA_reg, capt_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      top_reg <= CNT_MAX;
    end else begin
      top_reg <= topSel;
    end
  end

  assign topValue = top_reg;

  // Compare block after a software count write, lasts one tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_reg <= 1'b0;
    end else if (countWrite) begin
      block_reg <= 1'b1;
    end else if (timerTick) begin
      block_reg <= 1'b0;
    end
  end

  // Compare matches on a tick, unless blocked
  assign matchNowA = timerTick & ~block_reg & (countValue == cmpA_reg);
  assign matchNowB = timerTick & ~block_reg & (countValue == cmpB_reg);

  // Match seen on one tick raises its flag on the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendA_reg <= 1'b0;
      pendB_reg <= 1'b0;
    end else if (timerTick) begin
      pendA_reg <= matchNowA;
      pendB_reg <= matchNowB;
    end
  end

  // Force strobes reach the waveform unit only
  assign forceA = wrAccess & (paddr == ADDR_W'(OFS_CTRL)) & pwdata[CTRL_FORCE_A] & non_pwm(mode);
  assign forceB = wrAccess & (paddr == ADDR_W'(OFS_CTRL)) & pwdata[CTRL_FORCE_B] & non_pwm(mode);

  // Compare events to the waveform unit, forced or real
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpEvtA_reg <= 1'b0;
      cmpEvtB_reg <= 1'b0;
    end else begin
      cmpEvtA_reg <= matchNowA | forceA;
      cmpEvtB_reg <= matchNowB | forceB;
    end
  end

  assign compareEvtA = cmpEvtA_reg;
  assign compareEvtB = cmpEvtB_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wrap and top detection
  assign wrapKind = wrap_kind(mode);
  assign topNow   = timerTick & (countValue == topSel);

  always_comb begin
    case (wrapKind)
      WRAP_AT_MAX:    wrapNow = timerTick & (countValue == CNT_MAX);
      WRAP_AT_TOP:    wrapNow = topNow;
      WRAP_AT_BOTTOM: wrapNow = timerTick & countDown & (countValue == CNT_BOTTOM);
      default:        wrapNow = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag set and clear terms
  always_comb begin
    setMask = '0;
    setMask[BIT_CAPTURE] = capIf.captureEvt | (capt_is_top(mode) & topNow);
    setMask[BIT_MATCH_A] = timerTick & pendA_reg;
    setMask[BIT_MATCH_B] = timerTick & pendB_reg;
    setMask[BIT_WRAP]    = wrapNow;
  end

  always_comb begin
    clrMask = '0;
    if (wrAccess && paddr == ADDR_W'(OFS_FLAGS)) begin
      clrMask = pwdata[REG_W-1:0] & FLAG_VALID;
    end
    clrMask[BIT_WRAP]    = clrMask[BIT_WRAP] | vectorAck[0];
    clrMask[BIT_MATCH_A] = clrMask[BIT_MATCH_A] | vectorAck[1];
    clrMask[BIT_MATCH_B] = clrMask[BIT_MATCH_B] | vectorAck[2];
    clrMask[BIT_CAPTURE] = clrMask[BIT_CAPTURE] | vectorAck[3];
  end

  // Set wins over clear, zero bits leave flags alone
  assign flags_next = ((flags_reg & ~clrMask) | setMask) & FLAG_VALID;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests, one per vector
  assign vecFlag = {flags_reg[BIT_CAPTURE] & mask_reg[BIT_CAPTURE],
                    flags_reg[BIT_MATCH_B] & mask_reg[BIT_MATCH_B],
                    flags_reg[BIT_MATCH_A] & mask_reg[BIT_MATCH_A],
                    flags_reg[BIT_WRAP] & mask_reg[BIT_WRAP]};
  assign irqReq  = vecFlag & {4{globalIntEn}};
  assign irq     = |vecFlag;

endmodule // tef_timer_flags

// file: tb/tb.sv
// Self-checking bench for the timer event flag block.
// Assumes a 100 MHz clock and the core model on the vector side.
`timescale 1ns/1ps
module tb;
  import tef_pkg::*;
  ////////////////////////////////////////
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        timerTick, countDown, countWrite, capPin, globalIntEn, irq, ackEn, evtA, evtB;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] countValue, topValue, cA, cB;
  logic [3:0]  vectorAck, irqReq;
  logic [2:0]  ackDelay;
  int          num_errors, check_count, n;
  logic [15:0] cnts [5]  = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h0000};

  tef_timer_flags #(.ADDR_W(8)) tef_timer_flags_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerTick(timerTick), .countValue(countValue), .countDown(countDown), .countWrite(countWrite),
    .captureInputPin(capPin), .globalIntEn(globalIntEn), .vectorAck(vectorAck), .irqReq(irqReq), .irq(irq),
    .compareEvtA(evtA), .compareEvtB(evtB), .topValue(topValue));
  tef_core_model tef_core_model_i (.clk(clk), .rst_n(rst_n), .irqReq(irqReq), .ackEn(ackEn),
    .ackDelay(ackDelay), .vectorAck(vectorAck));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////
  // Wrap point per mode, counting down in the dual-slope modes
  function automatic logic wrapSet(input logic [3:0] m, input logic [15:0] c);
    case (m)
      4'h0, 4'h4, 4'hc: return c == CNT_MAX;
      4'h5: return c == TOP_8BIT;
      4'h6: return c == TOP_9BIT;
      4'h7: return c == TOP_10BIT;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: return c == CNT_BOTTOM;
      4'he: return c == cA + 16'h4000;
      4'hf: return c == cA;
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // One timer clock at count value c
  task automatic tick(input logic [15:0] c);
    @(posedge clk);
    timerTick <= 1'b1;
    countValue <= c;
    @(posedge clk);
    timerTick <= 1'b0;
  endtask

  task automatic conclude();
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, timerTick, countDown, countWrite, capPin, globalIntEn, ackEn} = '0;
    {paddr, pwdata, countValue, ackDelay} = '0;
    void'($urandom(32'hf4cf51e6));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc("flags reset", OFS_FLAGS, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, OFS_MASK, 32'h27);
    rdc("mask", OFS_MASK, 32'h27);
    globalIntEn <= 1'b1;
    // Random matches on both channels, then clears
    for (int i = 0; i < 8; i++) begin
      cA = 16'($urandom % 32'h7f00);
      cB = cA + 16'h8000;
      apb(1'b1, OFS_CMPA, {16'h0, cA});
      apb(1'b1, OFS_CMPB, {16'h0, cB});
      tick(cA);
      tick(cA + 16'h1);
      rdc("match a", OFS_FLAGS, 32'h2);
      tick(cB);
      tick(cB + 16'h1);
      rdc("match b", OFS_FLAGS, 32'h6);
      apb(1'b1, OFS_FLAGS, 32'h2);
      rdc("clear a only", OFS_FLAGS, 32'h4);
      apb(1'b1, OFS_FLAGS, 32'h0);
      rdc("zero write", OFS_FLAGS, 32'h4);
      apb(1'b1, OFS_FLAGS, 32'hff);
    end
    globalIntEn <= 1'b0;
    // Count write hides the next compare
    @(posedge clk);
    countWrite <= 1'b1;
    @(posedge clk);
    countWrite <= 1'b0;
    tick(cA);
    tick(cA + 16'h1);
    rdc("count write", OFS_FLAGS, 32'h0);
    tick(cA);
    tick(cA + 16'h1);
    @(negedge clk);
    chk("req gated", 32'h0, {28'h0, irqReq});
    chk("irq line", 32'h1, {31'h0, irq});
    @(posedge clk);
    globalIntEn <= 1'b1;
    @(negedge clk);
    chk("req enabled", 32'h2, {28'h0, irqReq});
    apb(1'b1, OFS_MASK, 32'h25);
    @(negedge clk);
    chk("req masked", 32'h0, {28'h0, irqReq});
    apb(1'b1, OFS_MASK, 32'h27);
    // Force strobes
    apb(1'b1, OFS_FLAGS, 32'hff);
    apb(1'b1, OFS_CTRL, 32'hc0);
    @(negedge clk);
    chk("force events", 32'h3, {30'h0, evtA, evtB});
    repeat (3) @(posedge clk);
    rdc("force", OFS_FLAGS, 32'h0);
    rdc("ctrl strobes", OFS_CTRL, 32'h0);
    // Rising capture edge
    apb(1'b1, OFS_CTRL, 32'h10);
    capPin <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("capture", OFS_FLAGS, 32'h20);
    rdc("capture value", OFS_CAPT, {16'h0, countValue});
    apb(1'b1, OFS_FLAGS, 32'hff);
    capPin <= 1'b0;
    repeat (3) @(posedge clk);
    rdc("falling edge", OFS_FLAGS, 32'h0);
    // Capture register as top
    apb(1'b1, OFS_CTRL, 32'h0c);
    apb(1'b1, OFS_CAPT, {16'h0, cA + 16'h4000});
    tick(cA + 16'h4000);
    tick(cA + 16'h4001);
    rdc("capture top", OFS_FLAGS, 32'h20);
    chk("top value", {16'h0, cA + 16'h4000}, {16'h0, topValue});
    // Wrap point in every mode of the table
    countDown <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      foreach (cnts[k]) begin
        apb(1'b1, OFS_FLAGS, 32'hff);
        apb(1'b1, OFS_CTRL, {28'h0, 4'(m)});
        tick(cnts[k]);
        tick(16'h5555);
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk("wrap", {31'h0, wrapSet(4'(m), cnts[k])}, {31'h0, rd[0]});
      end
    end
    // Core executes vectors
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_FLAGS, 32'hff);
    ackDelay <= 3'($urandom);
    ackEn <= 1'b1;
    tick(16'hffff);
    tick(cA);
    tick(cA + 16'h1);
    tick(cB);
    tick(cB + 16'h1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irqReq !== 4'h0 && n < 60);
    chk("vector wait", 32'h0, {28'h0, irqReq});
    rdc("vector clear", OFS_FLAGS, 32'h0);
    conclude();
  end
endmodule // tb

// file: tb/tef_core_model.sv
// Model of the core's vector logic: executes the lowest pending vector.
// Assumes requests are levels and one ack pulse clears one flag.
`timescale 1ns/1ps
module tef_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Interrupt side
  input  wire logic [3:0] irqReq,
  input  wire logic       ackEn,
  input  wire logic [2:0] ackDelay,
  output logic      [3:0] vectorAck
);
  logic [2:0] waitCnt;
  logic       busy;
  // Wait ackDelay cycles, pulse one vector, then let the flag drop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt   <= 3'h0;
      busy      <= 1'b0;
      vectorAck <= 4'h0;
    end else begin
      vectorAck <= 4'h0;
      if (busy) begin
        busy <= 1'b0;
      end else if (ackEn && irqReq != 4'h0) begin
        if (waitCnt == ackDelay) begin
          vectorAck <= irqReq & (~irqReq + 4'h1);
          waitCnt   <= 3'h0;
          busy      <= 1'b1;
        end else begin
          waitCnt <= waitCnt + 3'h1;
        end
      end else begin
        waitCnt <= 3'h0;
      end
    end
  end
endmodule // tef_core_model

// file: tb/tef_timer_flags_sva.sv
// Checker for the timer event flag block, watching top-level ports only.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module tef_timer_flags_sva
  import tef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  // Timer and core
  input wire logic              timerTick,
  input wire logic              globalIntEn,
  input wire logic [3:0]        vectorAck,
  input wire logic [3:0]        irqReq,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic flagAcc;
  // Access phase aimed at the flag register
  assign flagAcc = psel && penable && (paddr == ADDR_W'(OFS_FLAGS));

  unused_bits_a: assert property (flagAcc && !pwrite |-> prdata[7:6] == 2'b00 && prdata[4:3] == 2'b00)
    else $error("unused flag bits read nonzero");
  irq_gate_a: assert property (!globalIntEn |-> irqReq == 4'h0)
    else $error("request without global enable");
  irq_any_a: assert property (irqReq != 4'h0 |-> irq)
    else $error("request without interrupt line");
  wrap_ack_a: assert property (vectorAck[0] && !timerTick |=> !irqReq[0])
    else $error("wrap flag survives its vector");
  match_ack_a: assert property (vectorAck[2:1] != 2'b00 && !timerTick |=> (irqReq[2:1] & $past(vectorAck[2:1])) == 2'b00)
    else $error("match flag survives its vector");
  clear_one_a: assert property (flagAcc && pwrite && pwdata[1] && !timerTick |=> !irqReq[1])
    else $error("write one left match a flag set");
  keep_other_a: assert property (flagAcc && pwrite && !pwdata[2] && irqReq[2] && !vectorAck[2] |=> irqReq[2] || !globalIntEn)
    else $error("zero write cleared match b flag");
  match_b_tick_a: assert property ($rose(irqReq[2]) && $past(globalIntEn) && !$past(psel) |-> $past(timerTick))
    else $error("match b flag set off a tick");
  match_a_tick_a: assert property ($rose(irqReq[1]) && $past(globalIntEn) && !$past(psel) |-> $past(timerTick))
    else $error("match a flag set off a tick");
endmodule // tef_timer_flags_sva

bind tef_timer_flags tef_timer_flags_sva #(.ADDR_W(ADDR_W)) tef_timer_flags_sva_i (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .timerTick(timerTick), .globalIntEn(globalIntEn), .vectorAck(vectorAck), .irqReq(irqReq), .irq(irq));
